/* File: obpr_option_decode.v */
// Summary of operation
// RULE1: Lock code blocks debug reads, keeps writes
// RULE2: Size code zero: no protected boot area
// RULE3: Size code one protects pages 0-1
// RULE4: Size code two protects pages 0-3
// RULE5: Larger codes protect larger area, to 255
// RULE6: Select 7 picks timer2 ch1 or beeper
// RULE7: Select 6 picks analog or I2C pins
// RULE8: Select 5 picks analog or timer1 signals
// RULE9: Select 4 set is reserved, never written
// RULE10: Select 3 picks timer3 ch2 or break
// RULE11: Select 2 picks timer3 ch2 or clkout
// RULE12: Select 2 wins over select 3
// RULE13: Select 1 swaps the two timer channels
// RULE14: Select 0 picks timer2 ch2 or trigger
// RULE15: Slow oscillator as sysclk only if allowed
// RULE16: Latch options at reset release, hold
`timescale 1ns/1ns
`include "obpr_consts.vh"

module obpr_option_decode (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst,

    // Option bytes from non-volatile store
    input  wire [7:0] readout_protect_option,
    input  wire [7:0] boot_area_option,
    input  wire [7:0] pin_remap_option,
    input  wire [7:0] clock_option_byte,
    input  wire [7:0] clock_option_byte_inverted,

    // Debug link requests
    input  wire       dbg_rd_req,
    input  wire       dbg_wr_req,

    // Flash write request
    input  wire       flash_wr_req,
    input  wire [7:0] flash_wr_page,

    // System clock switch request
    input  wire       slow_osc_sel_req,

    // Peripheral outputs toward pins
    input  wire       timer2_channel1,
    input  wire       timer2_channel2,
    input  wire       timer2_channel3,
    input  wire       timer3_channel1,
    input  wire       timer3_channel2,
    input  wire       beep_out,
    input  wire       timer1_channel3_complement,
    input  wire       timer1_channel2_complement,
    input  wire       timer1_channel1_complement,
    input  wire       configurable_clock_output,
    input  wire       i2c_sda_drive_low,
    input  wire       i2c_scl_drive_low,

    // Pin input levels
    input  wire       pb5_in,
    input  wire       pb4_in,
    input  wire       pb3_in,
    input  wire       pd0_in,
    input  wire       pd3_in,
    input  wire       pd7_in,

    // Pin drive
    output reg        pa3_out_ff,
    output reg        pa3_oe_ff,
    output reg        pd2_out_ff,
    output reg        pd2_oe_ff,
    output reg        pd4_out_ff,
    output reg        pd4_oe_ff,
    output reg        pd0_out_ff,
    output reg        pd0_oe_ff,
    output reg        pd3_out_ff,
    output reg        pd3_oe_ff,
    output reg        pb5_out_ff,
    output reg        pb5_oe_ff,
    output reg        pb4_out_ff,
    output reg        pb4_oe_ff,
    output reg  [2:0] pb2_0_out_ff,
    output reg  [2:0] pb2_0_oe_ff,

    // Analog switch enables for port B pins 5..0
    output reg  [5:0] analog_input_en_ff,

    // Pin inputs toward peripherals
    output reg        top_level_interrupt_input_ff,
    output reg        timer1_break_input_ff,
    output reg        timer1_external_trigger_ff,
    output reg        converter_external_trigger_ff,
    output reg        i2c_sda_in_ff,
    output reg        i2c_scl_in_ff,

    // Protection and clock decisions
    output reg        readout_locked_ff,
    output reg        dbg_rd_grant_ff,
    output reg        dbg_wr_grant_ff,
    output reg        boot_area_present_ff,
    output reg  [7:0] boot_area_last_page_ff,
    output reg        flash_wr_allow_ff,
    output reg        slow_osc_sysclk_allow_ff,
    output reg        slow_osc_sel_grant_ff,

    // Status
    output reg        cfg_valid_ff,
    output reg        clock_option_err_ff,
    output reg        remap_reserved_ff,
    output reg  [1:0] pd0_func_ff
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function [8:0] last_page;
    input [7:0] code;
    reg   [8:0] top;
    begin
        top = {code, 1'b0} - 9'h001;
        if (code == `OBPR_BOOT_NONE) begin
            last_page = 9'h000;
        end else if (top > {1'b0, `OBPR_LAST_PAGE}) begin
            last_page = {1'b0, `OBPR_LAST_PAGE};
        end else begin
            last_page = top;
        end
    end
endfunction

function pick;
    input sel;
    input when_set;
    input when_clear;
    begin
        pick = sel ? when_set : when_clear;
    end
endfunction

// ----------------------------------------------------------------
// Latched option state
// ----------------------------------------------------------------
reg  [7:0] readout_lock_code_ff;
reg  [7:0] boot_area_size_code_ff;
reg  [7:0] remap_ff;
reg        slow_allow_raw_ff;
reg        clk_byte_match_ff;
reg        captured_ff;

wire remap_sel_7 = remap_ff[`OBPR_SEL7_BIT];
wire remap_sel_6 = remap_ff[`OBPR_SEL6_BIT];
wire remap_sel_5 = remap_ff[`OBPR_SEL5_BIT];
wire remap_sel_4 = remap_ff[`OBPR_SEL4_BIT];
wire remap_sel_3 = remap_ff[`OBPR_SEL3_BIT];
wire remap_sel_2 = remap_ff[`OBPR_SEL2_BIT];
wire remap_sel_1 = remap_ff[`OBPR_SEL1_BIT];
wire remap_sel_0 = remap_ff[`OBPR_SEL0_BIT];

// RULE16: capture once after release
// Store sits still after reset; a later edit only lands on next reset
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        readout_lock_code_ff   <= `OBPR_BYTE_RST;
        boot_area_size_code_ff <= `OBPR_BYTE_RST;
        remap_ff               <= `OBPR_BYTE_RST;
        slow_allow_raw_ff      <= 1'b0;
        clk_byte_match_ff      <= 1'b0;
        captured_ff            <= 1'b0;
    end else if (!captured_ff) begin
        readout_lock_code_ff   <= readout_protect_option;
        boot_area_size_code_ff <= boot_area_option;
        remap_ff               <= pin_remap_option;
        slow_allow_raw_ff      <= clock_option_byte[`OBPR_SLOW_ALLOW_BIT];
        clk_byte_match_ff      <= (clock_option_byte == ~clock_option_byte_inverted);
        captured_ff            <= 1'b1;
    end
end

// ----------------------------------------------------------------
// Decode of latched values
// ----------------------------------------------------------------
wire [8:0] nxt_last_page     = last_page(boot_area_size_code_ff);
// RULE2: code zero means no area
wire       nxt_area_present  = (boot_area_size_code_ff != `OBPR_BOOT_NONE);
// RULE3: RULE4: RULE5: pages 0..last protected
wire       page_in_area      = nxt_area_present &&
                               ({1'b0, flash_wr_page} <= nxt_last_page);
// RULE1: lock code compare
wire       nxt_locked        = (readout_lock_code_ff == `OBPR_READOUT_LOCK_CODE);
// Corrupted pair reads as not allowed, the safe side
wire       nxt_slow_allow    = slow_allow_raw_ff && clk_byte_match_ff;

// RULE12: select 2 checked first
// RULE10: RULE11: pin D0 owner
reg  [1:0] nxt_pd0_func;
always @* begin
    if (remap_sel_2) begin
        nxt_pd0_func = `OBPR_PD0_CLKOUT;
    end else if (remap_sel_3) begin
        nxt_pd0_func = `OBPR_PD0_BREAK;
    end else begin
        nxt_pd0_func = `OBPR_PD0_TIM3;
    end
end

// ----------------------------------------------------------------
// Protection and clock outputs
// ----------------------------------------------------------------
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        cfg_valid_ff             <= 1'b0;
        readout_locked_ff        <= 1'b0;
        dbg_rd_grant_ff          <= 1'b0;
        dbg_wr_grant_ff          <= 1'b0;
        boot_area_present_ff     <= 1'b0;
        boot_area_last_page_ff   <= 8'h00;
        flash_wr_allow_ff        <= 1'b0;
        slow_osc_sysclk_allow_ff <= 1'b0;
        slow_osc_sel_grant_ff    <= 1'b0;
        clock_option_err_ff      <= 1'b0;
        remap_reserved_ff        <= 1'b0;
        pd0_func_ff              <= `OBPR_PD0_TIM3;
    end else begin
        cfg_valid_ff             <= captured_ff;
        readout_locked_ff        <= captured_ff && nxt_locked;

        // RULE1: reads stopped, writes pass
        dbg_rd_grant_ff          <= captured_ff && dbg_rd_req && !nxt_locked;
        dbg_wr_grant_ff          <= captured_ff && dbg_wr_req;
        boot_area_present_ff     <= captured_ff && nxt_area_present;
        boot_area_last_page_ff   <= nxt_last_page[7:0];

        // RULE2: RULE5: protected pages refuse writes
        flash_wr_allow_ff        <= captured_ff && flash_wr_req && !page_in_area;

        // RULE15: switch only when option allows
        slow_osc_sysclk_allow_ff <= captured_ff && nxt_slow_allow;
        slow_osc_sel_grant_ff    <= captured_ff && slow_osc_sel_req && nxt_slow_allow;
        clock_option_err_ff      <= captured_ff && !clk_byte_match_ff;

        // RULE9: reserved value only flagged
        remap_reserved_ff        <= captured_ff && remap_sel_4;
        pd0_func_ff              <= nxt_pd0_func;
    end
end

// ----------------------------------------------------------------
// Pin routing
// ----------------------------------------------------------------
// Pins stay released until options are captured, so no glitch
// of a wrong function reaches the board during start-up
always @(posedge mclk or posedge rst) begin
    if (rst) begin
        pa3_out_ff         <= 1'b0;
        pa3_oe_ff          <= 1'b0;
        pd2_out_ff         <= 1'b0;
        pd2_oe_ff          <= 1'b0;
        pd4_out_ff         <= 1'b0;
        pd4_oe_ff          <= 1'b0;
        pd0_out_ff         <= 1'b0;
        pd0_oe_ff          <= 1'b0;
        pd3_out_ff         <= 1'b0;
        pd3_oe_ff          <= 1'b0;
        pb5_out_ff         <= 1'b0;
        pb5_oe_ff          <= 1'b0;
        pb4_out_ff         <= 1'b0;
        pb4_oe_ff          <= 1'b0;
        pb2_0_out_ff       <= 3'h0;
        pb2_0_oe_ff        <= 3'h0;
        analog_input_en_ff <= 6'h00;
    end else begin
        // RULE13: channel swap between A3 and D2
        pa3_out_ff <= pick(remap_sel_1, timer3_channel1, timer2_channel3);
        pd2_out_ff <= pick(remap_sel_1, timer2_channel3, timer3_channel1);
        pa3_oe_ff  <= captured_ff;
        pd2_oe_ff  <= captured_ff;

        // RULE6: D4 owner
        pd4_out_ff <= pick(remap_sel_7, beep_out, timer2_channel1);
        pd4_oe_ff  <= captured_ff;

        // RULE10: RULE11: break is an input, so D0 released
        pd0_out_ff <= pick(remap_sel_2, configurable_clock_output, timer3_channel2);
        pd0_oe_ff  <= captured_ff && (nxt_pd0_func != `OBPR_PD0_BREAK);

        // RULE14: trigger is an input, so D3 released
        pd3_out_ff <= timer2_channel2;
        pd3_oe_ff  <= captured_ff && !remap_sel_0;

        // RULE7: open-drain I2C, low only while pulled
        pb5_out_ff <= 1'b0;
        pb4_out_ff <= 1'b0;
        pb5_oe_ff  <= captured_ff && remap_sel_6 && i2c_sda_drive_low;
        pb4_oe_ff  <= captured_ff && remap_sel_6 && i2c_scl_drive_low;

        // RULE8: timer1 complements on B2..B0
        pb2_0_out_ff <= {timer1_channel3_complement,
                         timer1_channel2_complement,
                         timer1_channel1_complement};
        pb2_0_oe_ff  <= {3{captured_ff && remap_sel_5}};

        // RULE7: RULE8: analog switches when clear
        analog_input_en_ff <= {{2{captured_ff && !remap_sel_6}},
                               {4{captured_ff && !remap_sel_5}}};
    end
end

// ----------------------------------------------------------------
// Inputs toward peripherals
// ----------------------------------------------------------------
// Unrouted inputs idle at their inactive level; I2C idles high
reg        nxt_irq_in;
reg        nxt_break_in;
reg        nxt_tim1_trig_in;
reg        nxt_conv_trig_in;
reg        nxt_sda_in;
reg        nxt_scl_in;

always @* begin
    // RULE9: D7 feeds the interrupt input once options are captured
    nxt_irq_in       = captured_ff && pd7_in;

    // RULE12: break only when select 2 clear
    nxt_break_in     = (nxt_pd0_func == `OBPR_PD0_BREAK) && pd0_in;

    // RULE8: trigger from B3
    nxt_tim1_trig_in = captured_ff && remap_sel_5 && pb3_in;

    // RULE14: trigger from D3
    nxt_conv_trig_in = captured_ff && remap_sel_0 && pd3_in;

    // RULE7: I2C lines from B5 and B4
    nxt_sda_in       = pick(captured_ff && remap_sel_6, pb5_in, 1'b1);
    nxt_scl_in       = pick(captured_ff && remap_sel_6, pb4_in, 1'b1);
end

always @(posedge mclk or posedge rst) begin
    if (rst) begin
        top_level_interrupt_input_ff  <= 1'b0;
        timer1_break_input_ff         <= 1'b0;
        timer1_external_trigger_ff    <= 1'b0;
        converter_external_trigger_ff <= 1'b0;
        i2c_sda_in_ff                 <= 1'b1;
        i2c_scl_in_ff                 <= 1'b1;
    end else begin
        top_level_interrupt_input_ff  <= nxt_irq_in;
        timer1_break_input_ff         <= nxt_break_in;
        timer1_external_trigger_ff    <= nxt_tim1_trig_in;
        converter_external_trigger_ff <= nxt_conv_trig_in;
        i2c_sda_in_ff                 <= nxt_sda_in;
        i2c_scl_in_ff                 <= nxt_scl_in;
    end
end

endmodule

/* File: obpr_consts.vh */
`ifndef OBPR_CONSTS_VH
`define OBPR_CONSTS_VH

// ----------------------------------------------------------------
// Option byte widths and codes
// ----------------------------------------------------------------
`define OBPR_BYTE_W            8
`define OBPR_READOUT_LOCK_CODE 8'haa
`define OBPR_BOOT_NONE         8'h00
`define OBPR_BOOT_TWO_PAGES    8'h01
`define OBPR_BOOT_FOUR_PAGES   8'h02
`define OBPR_BOOT_LARGE_MIN    8'h03
`define OBPR_LAST_PAGE         8'hff

// ----------------------------------------------------------------
// Remap option byte field positions
// ----------------------------------------------------------------
`define OBPR_SEL0_BIT          0
`define OBPR_SEL1_BIT          1
`define OBPR_SEL2_BIT          2
`define OBPR_SEL3_BIT          3
`define OBPR_SEL4_BIT          4
`define OBPR_SEL5_BIT          5
`define OBPR_SEL6_BIT          6
`define OBPR_SEL7_BIT          7

// ----------------------------------------------------------------
// Clock option byte field position, reset value and pin D0 function codes
// ----------------------------------------------------------------
`define OBPR_SLOW_ALLOW_BIT    3
`define OBPR_BYTE_RST          8'h00
`define OBPR_PD0_TIM3          2'h0
`define OBPR_PD0_BREAK         2'h1
`define OBPR_PD0_CLKOUT        2'h2

`endif

/* File: obpr_option_decode_sva.sv */
`timescale 1ns/1ns
module obpr_option_decode_sva (
    // Clock and reset
    input logic       mclk,
    input logic       rst,
    // Options and requests
    input logic [7:0] readout_protect_option,
    input logic [7:0] boot_area_option,
    input logic [7:0] pin_remap_option,
    input logic [7:0] clock_option_byte,
    input logic       dbg_rd_req,
    input logic       dbg_wr_req,
    input logic       slow_osc_sel_req,
    input logic       timer2_channel1,
    // Decoded outputs
    input logic       cfg_valid_ff,
    input logic       readout_locked_ff,
    input logic       dbg_rd_grant_ff,
    input logic       dbg_wr_grant_ff,
    input logic       boot_area_present_ff,
    input logic [7:0] boot_area_last_page_ff,
    input logic       slow_osc_sysclk_allow_ff,
    input logic       slow_osc_sel_grant_ff,
    input logic       pd0_oe_ff,
    input logic [1:0] pd0_func_ff,
    input logic       pd4_out_ff
);
    // ------------------------------------------------------------
    // Option decode checks (options held steady between resets)
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    rd_lock_gate_a: assert property (
        cfg_valid_ff |=> dbg_rd_grant_ff == ($past(dbg_rd_req) && !readout_locked_ff))
        else $error("debug read grant wrong");
    wr_grant_a: assert property (
        cfg_valid_ff |=> dbg_wr_grant_ff == $past(dbg_wr_req))
        else $error("debug write grant wrong");
    lock_code_a: assert property (
        cfg_valid_ff |-> readout_locked_ff == (readout_protect_option == 8'haa))
        else $error("readout lock decode wrong");
    boot_none_a: assert property (
        cfg_valid_ff && boot_area_option == 8'h00 |-> !boot_area_present_ff)
        else $error("boot area present for code zero");
    boot_small_a: assert property (
        cfg_valid_ff && boot_area_option inside {8'h01, 8'h02} |-> boot_area_present_ff &&
        boot_area_last_page_ff == {boot_area_option[6:0], 1'b0} - 8'h01)
        else $error("small boot area wrong");
    boot_large_a: assert property (
        cfg_valid_ff && boot_area_option >= 8'h03 |->
        boot_area_present_ff && boot_area_last_page_ff >= 8'h05)
        else $error("large boot area wrong");
    slow_grant_a: assert property (
        cfg_valid_ff |=> slow_osc_sel_grant_ff ==
        ($past(slow_osc_sel_req) && slow_osc_sysclk_allow_ff))
        else $error("slow oscillator grant wrong");
    slow_allow_a: assert property (
        cfg_valid_ff && !clock_option_byte[3] |-> !slow_osc_sysclk_allow_ff)
        else $error("slow oscillator allowed without option bit");
    pd0_prio_a: assert property (
        cfg_valid_ff && pin_remap_option[2] |-> pd0_func_ff == 2'h2 && pd0_oe_ff)
        else $error("port D0 clock output not chosen");
    pd4_route_a: assert property (
        cfg_valid_ff && !pin_remap_option[7] |=> pd4_out_ff == $past(timer2_channel1))
        else $error("port D4 timer route wrong");
    valid_time_a: assert property (
        $fell(rst) |-> !cfg_valid_ff ##1 !cfg_valid_ff ##1 cfg_valid_ff [*4])
        else $error("config valid timing wrong");
    hold_a: assert property (
        cfg_valid_ff |=> cfg_valid_ff && $stable(readout_locked_ff) &&
        $stable(boot_area_last_page_ff))
        else $error("latched options changed");
endmodule

bind obpr_option_decode obpr_option_decode_sva obpr_option_decode_sva_inst (.*);

/* File: tb.sv */
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [2:0]  lock;
        logic [9:0]  boot;
        logic [2:0]  slow;
        logic [1:0]  beep;
        logic [7:0]  i2c;
        logic [10:0] adc;
        logic [2:0]  irq;
        logic [4:0]  pd0;
        logic [3:0]  swap;
        logic [2:0]  trig;
    } obpr_exp_t;
    logic       mclk, rst, dbg_rd_req, dbg_wr_req, flash_wr_req, slow_osc_sel_req;
    logic [7:0] readout_protect_option, boot_area_option, pin_remap_option;
    logic [7:0] clock_option_byte, clock_option_byte_inverted, flash_wr_page;
    logic       timer2_channel1, timer2_channel2, timer2_channel3, timer3_channel1;
    logic       timer3_channel2, beep_out, timer1_channel3_complement;
    logic       timer1_channel2_complement, timer1_channel1_complement;
    logic       configurable_clock_output, i2c_sda_drive_low, i2c_scl_drive_low;
    logic       pb5_in, pb4_in, pb3_in, pd0_in, pd3_in, pd7_in;
    logic       pa3_out_ff, pa3_oe_ff, pd2_out_ff, pd2_oe_ff, pd4_out_ff, pd4_oe_ff;
    logic       pd0_out_ff, pd0_oe_ff, pd3_out_ff, pd3_oe_ff, pb5_out_ff, pb5_oe_ff;
    logic       pb4_out_ff, pb4_oe_ff, top_level_interrupt_input_ff, timer1_break_input_ff;
    logic       timer1_external_trigger_ff, converter_external_trigger_ff;
    logic       i2c_sda_in_ff, i2c_scl_in_ff, readout_locked_ff, dbg_rd_grant_ff;
    logic       dbg_wr_grant_ff, boot_area_present_ff, flash_wr_allow_ff;
    logic       slow_osc_sysclk_allow_ff, slow_osc_sel_grant_ff, cfg_valid_ff;
    logic       clock_option_err_ff, remap_reserved_ff;
    logic [2:0] pb2_0_out_ff, pb2_0_oe_ff;
    logic [5:0] analog_input_en_ff;
    logic [7:0] boot_area_last_page_ff;
    logic [1:0] pd0_func_ff;
    logic [7:0] boot_tab [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h7f, 8'h80, 8'hff};
    logic [7:0] remap_tab [4] = '{8'h0c, 8'h08, 8'hff, 8'h00};
    obpr_exp_t  obs;
    obpr_exp_t  q[$];
    int         err_count, compares, seed;

    obpr_option_decode obpr_option_decode_inst (.*);

    // Undriven pin values are masked by their enables
    assign obs = {dbg_rd_grant_ff, dbg_wr_grant_ff, readout_locked_ff, flash_wr_allow_ff,
        boot_area_present_ff, boot_area_last_page_ff, slow_osc_sysclk_allow_ff,
        slow_osc_sel_grant_ff, clock_option_err_ff, pd4_out_ff, pd4_oe_ff, pb5_out_ff,
        pb5_oe_ff, pb4_out_ff, pb4_oe_ff, i2c_sda_in_ff, i2c_scl_in_ff, analog_input_en_ff,
        pb2_0_out_ff & pb2_0_oe_ff, pb2_0_oe_ff, timer1_external_trigger_ff,
        top_level_interrupt_input_ff, remap_reserved_ff, cfg_valid_ff, pd0_out_ff & pd0_oe_ff,
        pd0_oe_ff, timer1_break_input_ff, pd0_func_ff, pa3_out_ff, pa3_oe_ff, pd2_out_ff,
        pd2_oe_ff, pd3_out_ff & pd3_oe_ff, pd3_oe_ff, converter_external_trigger_ff};

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function automatic logic [7:0] boot_last();
        if (boot_area_option == 8'h00) return 8'h00;
        if (boot_area_option[7]) return 8'hff;
        return {boot_area_option[6:0], 1'b0} - 8'h01;
    endfunction

    function automatic obpr_exp_t exp_calc();
        obpr_exp_t  e;
        logic [7:0] s;
        logic       pair, allow, lock, used;
        s = pin_remap_option;
        pair = clock_option_byte === ~clock_option_byte_inverted;
        allow = pair && clock_option_byte[3];
        lock = readout_protect_option == 8'haa;
        used = boot_area_option != 8'h00;
        e.lock = {dbg_rd_req & ~lock, dbg_wr_req, lock};
        e.boot = {flash_wr_req & ~(used && flash_wr_page <= boot_last()), used, boot_last()};
        e.slow = {allow, slow_osc_sel_req & allow, ~pair};
        e.beep = {s[7] ? beep_out : timer2_channel1, 1'b1};
        e.i2c = s[6] ? {1'b0, i2c_sda_drive_low, 1'b0, i2c_scl_drive_low, pb5_in, pb4_in, 2'b00}
                     : 8'h0f;
        e.adc = s[5] ? {4'h0, timer1_channel3_complement, timer1_channel2_complement,
                        timer1_channel1_complement, 3'h7, pb3_in} : 11'h780;
        e.irq = {pd7_in, 2'b01};
        e.pd0 = s[2] ? {configurable_clock_output, 4'b1010}
              : s[3] ? {2'b00, pd0_in, 2'h1} : {timer3_channel2, 4'b1000};
        e.swap = s[1] ? {timer3_channel1, 1'b1, timer2_channel3, 1'b1}
                      : {timer2_channel3, 1'b1, timer3_channel1, 1'b1};
        e.trig = s[0] ? {2'b00, pd3_in} : {timer2_channel2, 2'b10};
        return e;
    endfunction

    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic set_opts(input int run);
        logic [31:0] r;
        r = $random(seed);
        readout_protect_option = (run % 3 == 0) ? 8'haa : r[7:0];
        boot_area_option = run < 7 ? boot_tab[run] : r[15:8];
        pin_remap_option = (run < 4 ? remap_tab[run] : r[23:16]) & 8'hef;
        clock_option_byte = {r[31:28], run[0], r[26:24]};
        clock_option_byte_inverted = ~clock_option_byte ^ ((run % 4 == 3) ? 8'h10 : 8'h00);
    endtask

    task automatic drive_rand();
        logic [31:0] r;
        r = $random(seed);
        {dbg_rd_req, dbg_wr_req, flash_wr_req, slow_osc_sel_req, timer2_channel1,
         timer2_channel2, timer2_channel3, timer3_channel1, timer3_channel2, beep_out,
         timer1_channel3_complement, timer1_channel2_complement, timer1_channel1_complement,
         configurable_clock_output, i2c_sda_drive_low, i2c_scl_drive_low, pb5_in, pb4_in,
         pb3_in, pd0_in, pd3_in, pd7_in, flash_wr_page} = r[29:0];
        // Aim at the protected page boundary
        if (r[30]) begin
            flash_wr_page = boot_last() + {7'h00, r[31]};
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scoreboard and main sequence
    // ------------------------------------------------------------
    initial begin
        obpr_exp_t e;
        forever begin
            @(posedge mclk);
            #1;
            if (q.size() > 0) begin
                e = q.pop_front();
                check(11'(obs.lock), 11'(e.lock));
                check(11'(obs.boot), 11'(e.boot));
                check(11'(obs.slow), 11'(e.slow));
                check(11'(obs.beep), 11'(e.beep));
                check(11'(obs.i2c), 11'(e.i2c));
                check(obs.adc, e.adc);
                check(11'(obs.irq), 11'(e.irq));
                check(11'(obs.pd0), 11'(e.pd0));
                check(11'(obs.swap), 11'(e.swap));
                check(11'(obs.trig), 11'(e.trig));
            end
        end
    end

    initial begin
        seed = 32'h3d882c32;
        err_count = 0;
        compares = 0;
        drive_rand();
        for (int run = 0; run < 14; run++) begin
            rst = 1'b1;
            set_opts(run);
            repeat (3) @(negedge mclk);
            check(11'({cfg_valid_ff, i2c_sda_in_ff, pd0_func_ff}), 11'h004);
            rst = 1'b0;
            @(negedge mclk);
            repeat (40) begin
                drive_rand();
                q.push_back(exp_calc());
                @(negedge mclk);
            end
        end
        final_report();
    end
endmodule
